// ---- logic/dic_buf2.sv ----
// Purpose: two-entry buffer between capture and converter core
// Assumes: single clock
// Notes:   passes a word straight through when empty so the core keeps
//          its one-cycle latency; entries fill while the core stalls or while a word is already held
module dic_buf2 import dic_pkg::*; (
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire logic              i_valid,
  input  wire logic [DATA_W-1:0] i_data,
  output logic                   o_in_ready,
  output logic                   o_valid,
  output logic [DATA_W-1:0]      o_data,
  input  wire logic              i_out_ready,
  output logic [1:0]             o_level
);
  logic [DATA_W-1:0] mem_q [BUF_DEPTH];
  logic              wr_q;
  logic              rd_q;
  logic [1:0]        cnt_q;
  logic              push;
  logic              pop;

  assign o_in_ready = (cnt_q != BUF_FULL);
  assign o_valid    = (cnt_q != BUF_EMPTY) || i_valid;
  assign o_data     = (cnt_q != BUF_EMPTY) ? mem_q[rd_q] : i_data;
  assign pop        = (cnt_q != BUF_EMPTY) && i_out_ready;
  assign push       = i_valid && o_in_ready && !((cnt_q == BUF_EMPTY) && i_out_ready);
  assign o_level    = cnt_q;

  always_ff @(posedge i_mclk)
  begin
    if (i_ce && push)
      mem_q[wr_q] <= i_data;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= BUF_EMPTY;
    end
    else if (i_ce)
    begin
      if (push)
        wr_q <= ~wr_q;
      if (pop)
        rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : dic_buf2

// ---- logic/dic_pkg.sv ----
// Purpose: shared constants of the converter input capture and power control block
// Assumes: a 250 MHz conversion clock
// Notes:   times are kept in their own unit and turned into cycle counts here
package dic_pkg;
  localparam int unsigned DATA_W       = 14;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CLK_MHZ      = 1000 / CLK_PERIOD_NS;

  // straight binary: all ones is full scale on the true output
  localparam logic [13:0] CODE_FULL    = 14'h3fff;
  localparam logic [13:0] CODE_ZERO    = 14'h0000;

  // power-up settle time after release of power-down (least time; CLK_MHZ rounds down)
  localparam int unsigned WAKE_US      = 3000;
  localparam int unsigned WAKE_CYC     = WAKE_US * CLK_MHZ;
  // power-down entry must finish within this (longest time, rounds down)
  localparam int unsigned ENTER_NS     = 5000;
  localparam int unsigned ENTER_CYC    = ENTER_NS / CLK_PERIOD_NS;

  // with the delay loop off the update interval must be at least 10 ns
  localparam int unsigned UPD_MIN_NS   = 10;
  localparam logic [1:0]  UPD_MIN_CYC  = 2'((UPD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int unsigned BUF_DEPTH    = 2;
  localparam logic [1:0]  BUF_FULL     = 2'h2;
  localparam logic [1:0]  BUF_EMPTY    = 2'h0;

  typedef enum logic [1:0] {DIC_PW_ON, DIC_PW_DOWN, DIC_PW_WAKE} dic_pw_t;
endpackage : dic_pkg

// ---- logic/dic_sync3.sv ----
// Purpose: three-stage synchroniser for a pin level
// Assumes: pin is asynchronous to i_mclk
// Notes:   output moves only once stages two and three agree
module dic_sync3 (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  input  wire logic i_pin,
  output logic      o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      o_level <= 1'b0;
    end
    else if (i_ce)
    begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        o_level <= s3_q;
    end
  end
endmodule : dic_sync3

// ---- logic/dic_top.sv ----
// Purpose: digital side of a 14-bit current-steering converter: word capture,
//          core update, delay-loop enable and power-down sequencing
// Assumes: data source runs on i_mclk; power-down and loop-disable pins are async
// Notes:   output codes stand for the steered current on each output
// Function
// - capture the whole input word on every rising clock edge
// - core takes captured word on next rising edge: one cycle latency
// - delay loop only aligns the capture clock, never changes output
// - input word is unsigned binary, bit 13 most significant
// - all-ones code puts full scale on true output, none on other
// - all-zeros code puts full scale on complementary output
// - true output is code scaled; complementary carries the remainder
// - power-down pin high switches the output current off
// - power-down entry under 5 us, recovery about 3 ms
// - power-down acts asynchronously to the clock, active high; here it is synchronised to i_mclk in three stages first
// - loop-disable high turns the loop off; rate then at most 100 MSPS
module dic_top import dic_pkg::*; #(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire logic [DATA_W-1:0] i_data_p,
  input  wire logic [DATA_W-1:0] i_data_n,
  input  wire logic              i_data_valid,
  output logic                   o_data_ready,
  input  wire logic              i_core_ready,
  input  wire logic              i_power_down,
  input  wire logic              i_delay_loop_disable,
  output logic [DATA_W-1:0]      o_true_current_output,
  output logic [DATA_W-1:0]      o_complementary_current_output,
  output logic                   o_core_strobe,
  output logic                   o_output_on,
  output logic                   o_powered_down,
  output logic                   o_dll_enable,
  output logic                   o_rate_fault
);
  import dic_pkg::*;

  localparam logic [19:0] WAKE_LAST = 20'(WAKE_CYCLES - 1);

  logic              rst_meta_q;
  logic              rst_n_q;
  logic              sleep_s;
  logic              loop_off_s;
  logic [DATA_W-1:0] cap_q;
  logic              cap_vld_q;
  logic              buf_in_ready;
  logic              buf_vld;
  logic [DATA_W-1:0] buf_data;
  logic [1:0]        buf_level;
  logic              core_take;
  logic [DATA_W-1:0] code_q;
  logic [DATA_W-1:0] code_d;
  dic_pw_t           pw_q;
  dic_pw_t           pw_d;
  logic [19:0]       wake_cnt_q;
  logic [1:0]        gap_q;

  // one bit from a differential pair
  function automatic logic [DATA_W-1:0] resolve(input logic [DATA_W-1:0] p, input logic [DATA_W-1:0] n);
    resolve = p & ~n;
  endfunction : resolve

  // reset enters asynchronously, leaves on the clock
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // pin is taken as-is: an open pin has no defined level to fall back on
  dic_sync3 u_sleep_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (rst_n_q),
    .i_ce    (i_ce),
    .i_pin   (i_power_down),
    .o_level (sleep_s)
  );

  dic_sync3 u_loop_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (rst_n_q),
    .i_ce    (i_ce),
    .i_pin   (i_delay_loop_disable),
    .o_level (loop_off_s)
  );

  // capture stage: every edge, all fourteen bits at once
  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cap_q     <= CODE_ZERO;
      cap_vld_q <= 1'b0;
    end
    else if (i_ce)
    begin
      cap_q     <= resolve(i_data_p, i_data_n);
      cap_vld_q <= i_data_valid && o_data_ready;
    end
  end

  // ready is registered, so a word may already be in flight when it drops;
  // demanding an empty buffer leaves room for that word and one more
  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      o_data_ready <= 1'b0;
    else if (i_ce)
      o_data_ready <= (buf_level == BUF_EMPTY) && buf_in_ready && !(cap_vld_q && !core_take);
  end

  dic_buf2 u_buf (
    .i_mclk      (i_mclk),
    .i_rst_n     (rst_n_q),
    .i_ce        (i_ce),
    .i_valid     (cap_vld_q),
    .i_data      (cap_q),
    .o_in_ready  (buf_in_ready),
    .o_valid     (buf_vld),
    .o_data      (buf_data),
    .i_out_ready (core_take),
    .o_level     (buf_level)
  );

  // while asleep the core drains the buffer so stale words are not replayed
  assign core_take = buf_vld && (i_core_ready || (pw_q != DIC_PW_ON));
  assign code_d    = (core_take && (pw_q == DIC_PW_ON)) ? buf_data : code_q;

  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      code_q        <= CODE_ZERO;
      o_core_strobe <= 1'b0;
    end
    else if (i_ce)
    begin
      code_q        <= code_d;
      o_core_strobe <= core_take && (pw_q == DIC_PW_ON);
    end
  end

  // power sequencing
  always_comb
  begin
    pw_d = pw_q;
    unique case (pw_q)
      DIC_PW_ON:   if (sleep_s) pw_d = DIC_PW_DOWN;
      DIC_PW_DOWN: if (!sleep_s) pw_d = DIC_PW_WAKE;
      DIC_PW_WAKE:
      begin
        if (sleep_s)
          pw_d = DIC_PW_DOWN;
        else if (wake_cnt_q == WAKE_LAST)
          pw_d = DIC_PW_ON;
      end
      default:     pw_d = DIC_PW_DOWN;
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pw_q       <= DIC_PW_ON;
      wake_cnt_q <= 20'h00000;
    end
    else if (i_ce)
    begin
      pw_q <= pw_d;
      if (pw_q == DIC_PW_WAKE)
        wake_cnt_q <= wake_cnt_q + 20'h00001;
      else
        wake_cnt_q <= 20'h00000;
    end
  end

  // code maps straight to steered current; both off while not running
  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      o_true_current_output          <= CODE_ZERO;
      o_complementary_current_output <= CODE_ZERO;
      o_output_on                    <= 1'b0;
      o_powered_down                 <= 1'b0;
    end
    else if (i_ce)
    begin
      o_output_on    <= (pw_d == DIC_PW_ON);
      o_powered_down <= (pw_d != DIC_PW_ON);
      if (pw_d == DIC_PW_ON)
      begin
        o_true_current_output          <= code_d;
        o_complementary_current_output <= CODE_FULL - code_d;
      end
      else
      begin
        o_true_current_output          <= CODE_ZERO;
        o_complementary_current_output <= CODE_ZERO;
      end
    end
  end

  // the loop only moves the capture clock phase; nothing in the data path reads it
  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      o_dll_enable <= 1'b0;
    else if (i_ce)
      o_dll_enable <= !loop_off_s;
  end

  // update spacing watch while the loop is off; a fault is only reported,
  // the word is still converted
  always_ff @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      gap_q        <= UPD_MIN_CYC;
      o_rate_fault <= 1'b0;
    end
    else if (i_ce)
    begin
      if (cap_vld_q)
        gap_q <= 2'h1;
      else if (gap_q != UPD_MIN_CYC)
        gap_q <= gap_q + 2'h1;
      o_rate_fault <= cap_vld_q && loop_off_s && (gap_q < UPD_MIN_CYC);
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!rst_n_q);

  chk_bit_resolve: assert property (i_ce |=> cap_q == $past(resolve(i_data_p, i_data_n)))
    else $error("captured word does not match resolved pairs");

  chk_capture_core: assert property (
    i_ce && cap_vld_q && buf_level == BUF_EMPTY && i_core_ready && pw_q == DIC_PW_ON
    |=> code_q == $past(cap_q) && o_core_strobe)
    else $error("captured word missed the next core edge");

  chk_full_ones: assert property (o_true_current_output == CODE_FULL |-> o_complementary_current_output == CODE_ZERO)
    else $error("full-scale code leaves current on complementary output");

  chk_zero_code: assert property (
    o_output_on && o_true_current_output == CODE_ZERO |-> o_complementary_current_output == CODE_FULL)
    else $error("zero code does not steer full scale to complementary output");

  chk_sum_full: assert property (
    o_output_on |-> 15'(o_true_current_output) + 15'(o_complementary_current_output) == 15'(CODE_FULL))
    else $error("outputs do not sum to full scale");

  chk_sleep_off: assert property (
    sleep_s && i_ce |=> !o_output_on && o_true_current_output == CODE_ZERO
                         && o_complementary_current_output == CODE_ZERO)
    else $error("current still on during power-down");

  chk_wake_time: assert property ($rose(o_output_on) |-> $past(wake_cnt_q) == WAKE_LAST
                                  || $past(pw_q) == DIC_PW_ON)
    else $error("output resumed before wake time elapsed");

  chk_rate_flag: assert property (
    i_ce && cap_vld_q && loop_off_s && gap_q == 2'h1 |=> o_rate_fault)
    else $error("back-to-back update with loop off not flagged");

  chk_rate_quiet: assert property (
    i_ce && cap_vld_q && gap_q == UPD_MIN_CYC |=> !o_rate_fault)
    else $error("spaced update flagged as too fast");

  chk_loop_mirror: assert property (i_ce |=> o_dll_enable == !$past(loop_off_s))
    else $error("loop enable does not follow its pin");

  // a word is only captured when the buffer can still take it
  chk_buf_room: assert property (
    cap_vld_q |-> buf_in_ready)
    else $error("captured word met a full buffer");

  chk_quiet_off: assert property (
    !o_output_on |-> o_true_current_output == CODE_ZERO && o_complementary_current_output == CODE_ZERO)
    else $error("current present while output is off");

  chk_sleep_strobe: assert property (
    i_ce && pw_q != DIC_PW_ON |=> !o_core_strobe)
    else $error("core strobed while not running");
endmodule : dic_top

// ---- verification/dic_src_model.sv ----
// Purpose: data source model driving differential words into the capture block
// Assumes: the source runs on the conversion clock
// Notes:   a word is held until taken; released lines show a changing pattern
module dic_src_model (
  input  wire logic                        i_mclk,
  input  wire logic                        i_send,
  input  wire logic [dic_pkg::DATA_W-1:0]  i_word,
  input  wire logic [dic_pkg::DATA_W-1:0]  i_eq_mask,
  input  wire logic                        i_ready,
  output logic      [dic_pkg::DATA_W-1:0]  o_p,
  output logic      [dic_pkg::DATA_W-1:0]  o_n,
  output logic                             o_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import dic_pkg::*;

  initial
  begin
    o_p = 14'h0000;
    o_n = 14'h3fff;
    o_valid = 1'b0;
  end

  // masked bits force the n line high, so set bits drive both lines high, a fault the bench asks for on purpose
  always @(posedge i_mclk)
  begin
    if (!o_valid || i_ready)
    begin
      o_valid <= i_send;
      o_p     <= i_send ? i_word : ~o_p;
      o_n     <= i_send ? (~i_word | i_eq_mask) : ~o_n;
    end
  end
endmodule : dic_src_model

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the capture and power control block
// Assumes: wake wait shortened to 16 cycles
// Notes:   outputs are sampled at rising edges before that edge's updates land
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dic_pkg::*;

  // take edge, then the core edge launches the strobe; the sample after that sees it
  localparam int LAT = 2;
  typedef struct {logic [13:0] w; logic [13:0] m; logic [13:0] t;} dic_row_t;
  dic_row_t    rows [6] = '{'{14'h3fff, 14'h0000, 14'h3fff}, '{14'h0000, 14'h0000, 14'h0000},
                            '{14'h2000, 14'h0000, 14'h2000}, '{14'h0001, 14'h0000, 14'h0001},
                            '{14'h1234, 14'h0000, 14'h1234}, '{14'h3fff, 14'h00ff, 14'h3f00}};
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic        core_rdy = 1'b1;
  logic        pd       = 1'b0;
  logic        dis      = 1'b0;
  logic        sd       = 1'b0;
  logic [13:0] wd       = 14'h0000;
  logic [13:0] msk      = 14'h0000;
  logic [13:0] dp, dn, tru, cmp;
  logic        vld, rdy, stb, on, pdn, dll, rf;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          rfc = 0;
  int          tq [$];
  int          lq [$];
  logic [13:0] sq [$];
  logic [13:0] cq [$];

  always #2 clk = ~clk;

  dic_top #(.WAKE_CYCLES(16)) DUT (
    .i_mclk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_data_p(dp), .i_data_n(dn),
    .i_data_valid(vld), .o_data_ready(rdy), .i_core_ready(core_rdy), .i_power_down(pd),
    .i_delay_loop_disable(dis), .o_true_current_output(tru), .o_complementary_current_output(cmp),
    .o_core_strobe(stb), .o_output_on(on), .o_powered_down(pdn), .o_dll_enable(dll),
    .o_rate_fault(rf));

  dic_src_model src (.i_mclk(clk), .i_send(sd), .i_word(wd), .i_eq_mask(msk), .i_ready(rdy),
                     .o_p(dp), .o_n(dn), .o_valid(vld));

  always @(posedge clk)
  begin
    cyc++;
    if (vld === 1'b1 && rdy === 1'b1)
      tq.push_back(cyc);
    if (stb === 1'b1)
    begin
      sq.push_back(tru);
      cq.push_back(cmp);
      lq.push_back(tq.size() > 0 ? cyc - tq.pop_front() : -1);
    end
    if (rf === 1'b1)
      rfc++;
  end

  task automatic chk(input logic c, input string m);
    checks_done++;
    if (c !== 1'b1)
    begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic give_up(input string m);
    chk(1'b0, m);
    print_verdict();
  endtask : give_up

  // the model loads on the first edge where its slot is free
  task automatic send(input logic [13:0] w);
    sd <= 1'b1;
    wd <= w;
    for (int k = 0; k < 64; k++)
    begin
      @(posedge clk);
      if (vld !== 1'b1 || rdy === 1'b1)
        return;
    end
    give_up("send timed out");
  endtask : send

  task automatic wait_stb(input int n);
    for (int k = 0; k < 64; k++)
    begin
      if (sq.size() >= n)
        return;
      @(posedge clk);
    end
    give_up("strobe timed out");
  endtask : wait_stb

  task automatic clr;
    sq.delete();
    cq.delete();
    lq.delete();
    tq.delete();
  endtask : clr

  initial
  begin
    int k;
    int rf0;
    repeat (8) @(posedge clk);
    chk(on === 1'b0 && rdy === 1'b0 && tru === 14'h0000 && stb === 1'b0, "outputs in reset");
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 16 && rdy !== 1'b1; k++)
      @(posedge clk);
    chk(rdy === 1'b1 && on === 1'b1 && dll === 1'b1, "not running after reset");
    $display("test reset finished");
    foreach (rows[i])
    begin
      msk <= rows[i].m;
      send(rows[i].w);
      sd <= 1'b0;
      wait_stb(1);
      chk(lq.pop_front() == LAT, "latency");
      chk(sq.pop_front() === rows[i].t, "word");
      chk(cq.pop_front() === 14'h3fff - rows[i].t, "complement");
    end
    msk <= 14'h0000;
    $display("test codes finished");
    core_rdy <= 1'b0;
    send(14'h0aaa);
    send(14'h1555);
    sd <= 1'b0;
    repeat (6) @(posedge clk);
    chk(rdy === 1'b0 && stb === 1'b0, "stalled core still fed");
    core_rdy <= 1'b1;
    wait_stb(2);
    chk(sq.pop_front() === 14'h0aaa && sq.pop_front() === 14'h1555, "stall lost a word");
    clr();
    $display("test stall finished");
    dis <= 1'b1;
    repeat (8) @(posedge clk);
    chk(dll === 1'b0, "loop not off");
    rf0 = rfc;
    send(14'h0123);
    send(14'h0321);
    sd <= 1'b0;
    wait_stb(2);
    repeat (2) @(posedge clk);
    chk(rfc > rf0, "fast words not flagged");
    chk(sq.pop_front() === 14'h0123, "fast word one");
    chk(sq.pop_front() === 14'h0321, "fast word two");
    rf0 = rfc;
    send(14'h0111);
    sd <= 1'b0;
    repeat (6) @(posedge clk);
    send(14'h0222);
    sd <= 1'b0;
    wait_stb(2);
    repeat (4) @(posedge clk);
    chk(rfc == rf0, "spaced words flagged");
    chk(sq.pop_front() === 14'h0111, "spaced word one");
    chk(sq.pop_front() === 14'h0222, "spaced word two");
    dis <= 1'b0;
    repeat (8) @(posedge clk);
    chk(dll === 1'b1, "loop not back on");
    $display("test loop finished");
    clr();
    pd <= 1'b1;
    for (k = 0; k < 16 && pdn !== 1'b1; k++)
      @(posedge clk);
    chk(pdn === 1'b1 && on === 1'b0 && tru === 14'h0000 && cmp === 14'h0000, "no power down");
    send(14'h0777);
    sd <= 1'b0;
    repeat (8) @(posedge clk);
    chk(sq.size() == 0 && tru === 14'h0000, "converted while down");
    pd <= 1'b0;
    for (k = 0; k < 64 && on !== 1'b1; k++)
      @(posedge clk);
    chk(k >= 16 && on === 1'b1 && pdn === 1'b0, "wake time");
    clr();
    send(14'h3001);
    sd <= 1'b0;
    wait_stb(1);
    chk(sq.pop_front() === 14'h3001, "no resume");
    chk(lq.pop_front() == LAT, "resume latency");
    $display("test power finished");
    print_verdict();
  end
endmodule : testbench
